// ===== hdl/adsh_host_port.sv
// design: shared-pad two-wire / four-wire serial register port of the accelerometer
module adsh_host_port
  import adsh_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       sample_clk,
  input  wire logic       samp_rst_b,
  input  wire logic       samp_valid,
  input  wire adsh_axes_t samp_data,
  input  wire adsh_trim_t nvm_trim,
  input  wire logic       core_power_ok,
  input  wire logic       iface_select_pad,
  input  wire logic       shared_serial_clock_pad,
  input  wire logic       shared_serial_data_pad_in,
  output logic            shared_serial_data_pad_out,
  output logic            shared_serial_data_pad_oe,
  input  wire logic       output_or_addr_select_pad_in,
  output logic            output_or_addr_select_pad_out,
  output logic            output_or_addr_select_pad_oe,
  output logic            data_ready,
  output logic            int1_wake,
  output logic            int2_freefall,
  output logic            trim_loaded
);

  adsh_st_t        r;
  adsh_st_t        n;
  adsh_samp_st_t   s_r;
  adsh_samp_st_t   s_nxt;
  logic            scl_rise;
  logic            scl_fall;
  logic            bus_start;
  logic            bus_stop;
  logic            tog_edge;
  logic            meas_on;
  logic            wr_en;
  logic [6:0]      wr_a;
  logic [7:0]      wr_d;
  logic            rd_z;
  logic [7:0]      rd_v;
  logic [6:0]      spi_a;
  adsh_axes_t      fix;
  logic [2:0][7:0] ax;
  logic            wake_hit;
  logic            ff_hit;

  function automatic logic [7:0] adsh_rd(input adsh_st_t s, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a[6:3] == ADSH_A_CTRL[6:3] && 32'(a[2:0]) < ADSH_NREG) v = s.cfg[a[2:0]];
    if (a == ADSH_A_STATUS) begin
      v[ADSH_ST_DRDY] = s.drdy;
      v[ADSH_ST_OVR]  = s.ovr;
    end
    if (a == ADSH_A_OUT_X) v = s.outv.x;
    if (a == ADSH_A_OUT_Y) v = s.outv.y;
    if (a == ADSH_A_OUT_Z) v = s.outv.z;
    if (a == ADSH_A_SENS) v = s.trim.sens;
    if (a == ADSH_A_OFFS) v = s.trim.offs;
    return v;
  endfunction : adsh_rd

  function automatic logic [7:0] adsh_mag(input logic [7:0] v);
    return v[7] ? 8'(-v) : v;
  endfunction : adsh_mag

  // sample domain: hold the set and announce it by a toggle
  always_comb begin
    s_nxt = s_r;
    if (samp_valid) begin
      s_nxt.hold = samp_data;
      s_nxt.tog  = ~s_r.tog;
    end
  end

  always_ff @(posedge sample_clk) begin
    if (!samp_rst_b) s_r <= '0;
    else s_r <= s_nxt;
  end

  always_comb begin
    n         = r;
    wr_en     = 1'b0;
    wr_a      = 7'h00;
    wr_d      = 8'h00;
    rd_z      = 1'b0;
    rd_v      = 8'h00;
    spi_a     = 7'h00;
    // pads are asynchronous: two stages before any decision; oversampling covers 400 kHz
    n.scl_s1  = shared_serial_clock_pad;
    n.scl_s2  = r.scl_s1;
    n.scl_d   = r.scl_s2;
    n.sda_s1  = shared_serial_data_pad_in;
    n.sda_s2  = r.sda_s1;
    n.sda_d   = r.sda_s2;
    n.cs_s1   = iface_select_pad;
    n.cs_s2   = r.cs_s1;
    n.sa0_s1  = output_or_addr_select_pad_in;
    n.sa0_s2  = r.sa0_s1;
    n.pwr_s1  = core_power_ok;
    n.pwr_s2  = r.pwr_s1;
    n.tog_s1  = s_r.tog;
    n.tog_s2  = r.tog_s1;
    n.tog_d   = r.tog_s2;
    scl_rise  = r.scl_s2 & ~r.scl_d;
    scl_fall  = ~r.scl_s2 & r.scl_d;
    bus_start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    bus_stop  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
    tog_edge  = r.tog_s2 ^ r.tog_d;
    meas_on   = r.loaded & r.pwr_s2 & r.cfg[0][ADSH_CTRL_MEAS];

    if (!r.loaded) begin
      n.trim   = nvm_trim;
      n.loaded = 1'b1;
    end

    if (r.cs_s2) begin
      n.scnt    = 4'h0;
      n.srd     = 1'b0;
      n.spi_drv = 1'b0;
      if (bus_start) begin
        n.iph    = ADSH_I_ADDR;
        n.icnt   = ADSH_I2C_ARM;
        n.sda_oe = 1'b0;
      end else if (bus_stop) begin
        n.iph    = ADSH_I_IDLE;
        n.sda_oe = 1'b0;
      end else if (r.iph != ADSH_I_IDLE) begin
        if (scl_rise) begin
          if (r.icnt != ADSH_I2C_ACK) n.ish = {r.ish[6:0], r.sda_s2};
          else if (r.iph == ADSH_I_RD && r.sda_s2) n.iph = ADSH_I_IDLE;
        end
        if (scl_fall) begin
          n.icnt   = (r.icnt == ADSH_I2C_ACK) ? 4'h0 : 4'(r.icnt + 4'h1);
          n.sda_oe = 1'b0;
          if (r.icnt == ADSH_I2C_LAST) begin
            unique case (r.iph)
              ADSH_I_ADDR: begin
                if (r.ish[7:1] == {ADSH_ADDR_HI, r.sa0_s2}) begin
                  n.sda_oe = 1'b1;
                  n.iph    = r.ish[0] ? ADSH_I_RD : ADSH_I_SUB;
                end else begin
                  n.iph = ADSH_I_IDLE;
                end
              end
              ADSH_I_SUB: begin
                n.iptr   = r.ish[6:0];
                n.iinc   = r.ish[7];
                n.sda_oe = 1'b1;
                n.iph    = ADSH_I_WR;
              end
              ADSH_I_WR: begin
                wr_en    = 1'b1;
                wr_a     = r.iptr;
                wr_d     = r.ish;
                n.iptr   = 7'(r.iptr + {6'h00, r.iinc});
                n.sda_oe = 1'b1;
              end
              ADSH_I_RD: n.sda_oe = 1'b0;
              ADSH_I_IDLE: n.sda_oe = 1'b0;
            endcase
          end else if (r.icnt == ADSH_I2C_ACK && r.iph == ADSH_I_RD) begin
            rd_v     = adsh_rd(r, r.iptr);
            rd_z     = (r.iptr == ADSH_A_OUT_Z);
            n.ish    = rd_v;
            n.sda_oe = ~rd_v[7];
            n.iptr   = 7'(r.iptr + {6'h00, r.iinc});
          end else if (r.iph == ADSH_I_RD) begin
            n.sda_oe = ~r.ish[7];
          end
        end
      end
    end else begin
      n.iph    = ADSH_I_IDLE;
      n.sda_oe = 1'b0;
      if (scl_rise) begin
        n.ssh  = {r.ssh[6:0], r.sda_s2};
        n.scnt = (r.scnt == ADSH_SPI_WRAP) ? ADSH_SPI_BYTE0 : 4'(r.scnt + 4'h1);
        if (r.scnt == ADSH_SPI_HDR) begin
          spi_a  = {1'b0, r.ssh[4:0], r.sda_s2};
          n.srd  = r.ssh[6];
          n.sinc = r.ssh[5];
          n.sptr = spi_a;
          if (r.ssh[6]) begin
            rd_v   = adsh_rd(r, spi_a);
            rd_z   = (spi_a == ADSH_A_OUT_Z);
            n.sout = rd_v;
            n.sptr = 7'(spi_a + {6'h00, r.ssh[5]});
          end
        end else if (r.scnt == ADSH_SPI_WRAP) begin
          if (r.srd) begin
            rd_v   = adsh_rd(r, r.sptr);
            rd_z   = (r.sptr == ADSH_A_OUT_Z);
            n.sout = rd_v;
          end else begin
            wr_en  = 1'b1;
            wr_a   = r.sptr;
            wr_d   = {r.ssh[6:0], r.sda_s2};
          end
          n.sptr = 7'(r.sptr + {6'h00, r.sinc});
        end
      end
      if (scl_fall && r.srd && r.scnt >= ADSH_SPI_BYTE0) begin
        n.sdo_o   = r.sout[7];
        n.sout    = {r.sout[6:0], 1'b0};
        n.spi_drv = 1'b1;
      end
    end

    // host writes set mode, enables and thresholds of both interrupt pins
    if (wr_en && wr_a[6:3] == ADSH_A_CTRL[6:3] && 32'(wr_a[2:0]) < ADSH_NREG) begin
      n.cfg[wr_a[2:0]] = wr_d;
    end

    if (rd_z) begin
      n.drdy = 1'b0;
      n.ovr  = 1'b0;
    end

    fix.x    = 8'(s_r.hold.x - r.trim.offs);
    fix.y    = 8'(s_r.hold.y - r.trim.offs);
    fix.z    = 8'(s_r.hold.z - r.trim.offs);
    ax       = {fix.x, fix.y, fix.z};
    wake_hit = 1'b0;
    ff_hit   = |r.cfg[3][2:0];
    for (int i = 0; i < 3; i++) begin
      if (r.cfg[1][i] && adsh_mag(ax[i]) > r.cfg[2]) wake_hit = 1'b1;
      if (r.cfg[3][i] && !(adsh_mag(ax[i]) < r.cfg[4])) ff_hit = 1'b0;
    end
    // hold set is stable here: the toggle reaches this side long after the hold was written
    if (tog_edge && meas_on) begin
      n.outv     = fix;
      n.ovr      = r.drdy & ~rd_z;
      n.drdy     = 1'b1;
      n.int_wake = wake_hit;
      n.int_ff   = ff_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r        <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_d  <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_d  <= 1'b1;
      r.cs_s1  <= 1'b1;
      r.cs_s2  <= 1'b1;
      r.iph    <= ADSH_I_IDLE;
      r.cfg    <= {ADSH_CFG_RST, ADSH_CFG_RST, ADSH_CFG_RST, ADSH_CFG_RST, ADSH_CTRL_RST};
    end else begin
      r <= n;
    end
  end

  // open-drain in two-wire mode: the line is only ever pulled low
  assign shared_serial_data_pad_out    = r.cs_s2 ? 1'b0 : r.sdo_o;
  assign shared_serial_data_pad_oe     = r.cs_s2 ? r.sda_oe
                                                 : (r.spi_drv & r.cfg[0][ADSH_CTRL_3W]);
  assign output_or_addr_select_pad_out = r.sdo_o;
  assign output_or_addr_select_pad_oe  = ~r.cs_s2 & r.spi_drv & ~r.cfg[0][ADSH_CTRL_3W];
  assign data_ready                    = r.drdy;
  assign int1_wake                     = r.int_wake;
  assign int2_freefall                 = r.int_ff;
  assign trim_loaded                   = r.loaded;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  drdy_set_a:    assert property (tog_edge && meas_on |=> data_ready)
    else $error("data ready not raised after new sample");
  wake_pin_a:    assert property (tog_edge && meas_on |=> int1_wake == $past(wake_hit))
    else $error("wake pin does not follow detection");
  ff_pin_a:      assert property (tog_edge && meas_on |=> int2_freefall == $past(ff_hit))
    else $error("free-fall pin does not follow detection");
  trim_load_a:   assert property ($rose(trim_loaded) |-> r.trim == $past(nvm_trim))
    else $error("trim not copied from storage");
  spi_quiet_a:   assert property (r.cs_s2 |=> r.scnt == 4'h0 && !output_or_addr_select_pad_oe)
    else $error("serial framing active in two-wire mode");
  wire_mode_a:   assert property (r.cfg[0][ADSH_CTRL_3W] |-> !output_or_addr_select_pad_oe)
    else $error("address pad driven in 3-wire mode");
  bus_release_a: assert property (r.cs_s2 && r.iph == ADSH_I_IDLE |-> !shared_serial_data_pad_oe)
    else $error("data line held while bus idle");
  addr_ack_a:    assert property (r.cs_s2 && scl_fall && r.iph == ADSH_I_ADDR && r.icnt == ADSH_I2C_LAST
                                  && !bus_start && !bus_stop
                                  |=> shared_serial_data_pad_oe == ($past(r.ish[7:1]) == {ADSH_ADDR_HI,
                                      $past(r.sa0_s2)}))
    else $error("address acknowledge wrong");
  sub_ptr_a:     assert property (r.cs_s2 && scl_fall && r.iph == ADSH_I_SUB && r.icnt == ADSH_I2C_LAST
                                  && !bus_start && !bus_stop
                                  |=> r.iptr == $past(r.ish[6:0]) && r.iinc == $past(r.ish[7]))
    else $error("pointer byte not taken");
  spi_len_a:     assert property (!r.cs_s2 && scl_rise && r.scnt == ADSH_SPI_WRAP |=> r.scnt == ADSH_SPI_BYTE0)
    else $error("serial byte block length wrong");
  read_back_a:   assert property (wr_en && wr_a == ADSH_A_WAKE_TH |=> adsh_rd(r, ADSH_A_WAKE_TH) == $past(wr_d))
    else $error("written register does not read back");
  core_off_a:    assert property (!r.pwr_s2 |=> $stable(r.outv))
    else $error("measurement updated without core power");

  both_int_c:    cover property (int1_wake && int2_freefall);
  i2c_write_c:   cover property (r.cs_s2 && wr_en);
  spi_read_c:    cover property (!r.cs_s2 && r.spi_drv ##1 r.scnt == ADSH_SPI_WRAP);
  i2c_read_c:    cover property (r.iph == ADSH_I_RD && scl_fall && r.icnt == ADSH_I2C_ACK);

endmodule : adsh_host_port

// ===== pkg/adsh_pkg.sv
// package: constants, carriers and state layout of the dual serial host port
package adsh_pkg;

  // bus slave address, upper six bits; the low bit comes from the address-select pad
  localparam logic [5:0] ADSH_ADDR_HI   = 6'h0E;
  // writable configuration block at 7'h20 .. 7'h24
  localparam int         ADSH_NREG      = 5;
  localparam logic [6:0] ADSH_A_CTRL    = 7'h20;
  localparam logic [6:0] ADSH_A_WAKE_EN = 7'h21;
  localparam logic [6:0] ADSH_A_WAKE_TH = 7'h22;
  localparam logic [6:0] ADSH_A_FF_EN   = 7'h23;
  localparam logic [6:0] ADSH_A_FF_TH   = 7'h24;
  localparam logic [6:0] ADSH_A_STATUS  = 7'h27;
  localparam logic [6:0] ADSH_A_OUT_X   = 7'h28;
  localparam logic [6:0] ADSH_A_OUT_Y   = 7'h29;
  localparam logic [6:0] ADSH_A_OUT_Z   = 7'h2A;
  localparam logic [6:0] ADSH_A_SENS    = 7'h30;
  localparam logic [6:0] ADSH_A_OFFS    = 7'h31;
  // control fields and status fields
  localparam int         ADSH_CTRL_3W   = 0;
  localparam int         ADSH_CTRL_MEAS = 1;
  localparam int         ADSH_ST_DRDY   = 3;
  localparam int         ADSH_ST_OVR    = 7;
  localparam logic [7:0] ADSH_CTRL_RST  = 8'h02;
  localparam logic [7:0] ADSH_CFG_RST   = 8'h00;
  // bit counters of both protocols
  localparam logic [3:0] ADSH_I2C_LAST  = 4'h7;
  localparam logic [3:0] ADSH_I2C_ACK   = 4'h8;
  // loaded at a start: the clock fall that completes the start wraps it to zero
  localparam logic [3:0] ADSH_I2C_ARM   = 4'hF;
  localparam logic [3:0] ADSH_SPI_HDR   = 4'h7;
  localparam logic [3:0] ADSH_SPI_BYTE0 = 4'h8;
  localparam logic [3:0] ADSH_SPI_WRAP  = 4'hF;

  typedef struct packed {
    logic signed [7:0] x;
    logic signed [7:0] y;
    logic signed [7:0] z;
  } adsh_axes_t;

  typedef struct packed {
    logic        [7:0] sens;
    logic signed [7:0] offs;
  } adsh_trim_t;

  typedef enum logic [2:0] {ADSH_I_IDLE, ADSH_I_ADDR, ADSH_I_SUB, ADSH_I_WR, ADSH_I_RD} adsh_iph_t;

  typedef struct packed {
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic cs_s1, cs_s2;
    logic sa0_s1, sa0_s2;
    logic pwr_s1, pwr_s2;
    logic tog_s1, tog_s2, tog_d;
    logic                          loaded;
    adsh_trim_t                    trim;
    logic [ADSH_NREG-1:0][7:0]     cfg;
    adsh_axes_t                    outv;
    logic                          drdy, ovr, int_wake, int_ff;
    adsh_iph_t                     iph;
    logic [3:0]                    icnt;
    logic [7:0]                    ish;
    logic [6:0]                    iptr;
    logic                          iinc, sda_oe;
    logic [3:0]                    scnt;
    logic [7:0]                    ssh, sout;
    logic [6:0]                    sptr;
    logic                          sinc, srd, spi_drv, sdo_o;
  } adsh_st_t;

  typedef struct packed {
    adsh_axes_t hold;
    logic       tog;
  } adsh_samp_st_t;

endpackage : adsh_pkg

// ===== test/adsh_bm.sv
// partner model: bus master for the two-wire and serial-frame modes, with pad pull-ups
module adsh_bm (
  input  wire logic clk,
  input  wire logic dev_sda_out,
  input  wire logic dev_sda_oe,
  input  wire logic dev_sdo_out,
  input  wire logic dev_sdo_oe,
  input  wire logic sa0_strap,
  output logic      scl,
  output logic      cs,
  output logic      sda,
  output logic      sdo_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_sda;
  logic m_oe;
  // released data line rests high on its pull-up; the released address pad rests on sa0_strap
  assign sda     = (dev_sda_oe ? dev_sda_out : 1'b1) & (m_oe ? m_sda : 1'b1);
  assign sdo_pad = dev_sdo_oe ? dev_sdo_out : sa0_strap;
  initial begin
    scl   = 1'b1;
    cs    = 1'b1;
    m_sda = 1'b1;
    m_oe  = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask : tk
  // 52 clocks a bit keeps the bus below 400 kHz
  task automatic ibit(input logic b, output logic smp);
    tk(13);
    m_sda = b;
    m_oe  = 1'b1;
    tk(13);
    scl = 1'b1;
    tk(13);
    smp = sda;
    tk(13);
    scl = 1'b0;
  endtask : ibit
  task automatic iedge(input logic start);
    tk(13);
    m_sda = start;
    m_oe  = 1'b1;
    tk(13);
    scl = 1'b1;
    tk(13);
    m_sda = !start;
    tk(13);
    if (start) begin
      scl = 1'b0;
    end
  endtask : iedge
  task automatic ibyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      ibit(tx[i], rx[i]);
    end
    ibit(ack_in, ack);
  endtask : ibyte
  // the master frames and clocks every transfer; pointer kept over the repeated start
  task automatic i2c(input logic [7:0] bus_slave_address, input logic [7:0] sub, input logic rd, input int n,
                     inout logic [31:0] d, output logic nak);
    logic [7:0] rx;
    logic       a;
    iedge(1'b1);
    ibyte(bus_slave_address, 1'b1, rx, nak);
    if (!nak) begin
      ibyte(sub, 1'b1, rx, a);
      nak |= a;
      if (rd) begin
        iedge(1'b1);
        ibyte(bus_slave_address | 8'h01, 1'b1, rx, a);
        nak |= a;
      end
      for (int i = 0; i < n; i++) begin
        ibyte(rd ? 8'hFF : d[8*i +: 8], !rd || i == n - 1, rx, a);
        if (rd) begin
          d[8*i +: 8] = rx;
        end else begin
          nak |= a;
        end
      end
    end
    iedge(1'b0);
  endtask : i2c
  // 16 clocks plus 8 per extra byte; data set after the fall, clock idles high
  task automatic spi(input logic rd, input logic inc, input logic [5:0] ad, input int n, input logic keep_sel,
                     input logic three_w, inout logic [15:0] d);
    logic [7:0] hdr;
    hdr = {rd, inc, ad};
    cs  = keep_sel;
    tk(10);
    for (int i = 0; i < 8 + 8 * n; i++) begin
      scl   = 1'b0;
      m_oe  = !(three_w && rd && i >= 8);
      m_sda = (i < 8) ? hdr[7 - i] : d[23 - i];
      tk(10);
      scl = 1'b1;
      if (rd && i >= 8) begin
        d[23 - i] = three_w ? sda : sdo_pad;
      end
      tk(10);
    end
    cs   = 1'b1;
    m_oe = 1'b0;
    tk(10);
  endtask : spi
endmodule : adsh_bm

// ===== test/adsh_host_port_tb.sv
// testbench: both serial modes, trim load, sample path and core power loss
module adsh_host_port_tb
  import adsh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, sample_clk, samp_rst_b, samp_valid, core_power_ok, sa0_strap;
  adsh_axes_t  samp_data;
  adsh_trim_t  nvm_trim;
  logic        scl, cs, sda, sdo_pad, sda_out, sda_oe, sdo_out, sdo_oe;
  logic        data_ready, int1_wake, int2_freefall, trim_loaded, nak;
  logic [31:0] d;
  logic [15:0] s;
  int          err_total;
  int          comparisons;

  adsh_host_port u_adsh_host_port (
    .clk(clk), .rst_b(rst_b), .sample_clk(sample_clk), .samp_rst_b(samp_rst_b), .samp_valid(samp_valid),
    .samp_data(samp_data), .nvm_trim(nvm_trim), .core_power_ok(core_power_ok), .iface_select_pad(cs),
    .shared_serial_clock_pad(scl), .shared_serial_data_pad_in(sda), .shared_serial_data_pad_out(sda_out),
    .shared_serial_data_pad_oe(sda_oe), .output_or_addr_select_pad_in(sdo_pad),
    .output_or_addr_select_pad_out(sdo_out), .output_or_addr_select_pad_oe(sdo_oe), .data_ready(data_ready),
    .int1_wake(int1_wake), .int2_freefall(int2_freefall), .trim_loaded(trim_loaded));
  adsh_bm u_adsh_bm (
    .clk(clk), .dev_sda_out(sda_out), .dev_sda_oe(sda_oe), .dev_sdo_out(sdo_out), .dev_sdo_oe(sdo_oe),
    .sa0_strap(sa0_strap), .scl(scl), .cs(cs), .sda(sda), .sdo_pad(sdo_pad));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    sample_clk = 1'b0;
    #7;
    forever #6 sample_clk = ~sample_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask : tk
  task automatic wr(input logic [7:0] sub, input int n, input logic [31:0] v);
    d = v;
    u_adsh_bm.i2c({ADSH_ADDR_HI, sa0_strap, 1'b0}, sub, 1'b0, n, d, nak);
    check(nak, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] sub, input int n, input logic [31:0] exp);
    d = 32'h0;
    u_adsh_bm.i2c({ADSH_ADDR_HI, sa0_strap, 1'b0}, sub, 1'b1, n, d, nak);
    check(nak, 32'h0);
    check(d, exp);
  endtask : rd
  task automatic sp(input logic r, input logic [6:0] a, input int n, input logic tw, input logic [15:0] v);
    s = v;
    u_adsh_bm.spi(r, n > 1, a[5:0], n, 1'b0, tw, s);
  endtask : sp
  task automatic samp(input adsh_axes_t v);
    @(negedge sample_clk);
    samp_data  = v;
    samp_valid = 1'b1;
    @(negedge sample_clk);
    samp_valid = 1'b0;
  endtask : samp
  task automatic wait_ready();
    for (int i = 0; i < 20 && data_ready !== 1'b1; i++) begin
      @(negedge clk);
    end
    check(data_ready, 32'h1);
    if (data_ready !== 1'b1) begin
      test_done();
    end
    tk(2);
  endtask : wait_ready
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    rst_b         = 1'b0;
    samp_rst_b    = 1'b0;
    samp_valid    = 1'b0;
    samp_data     = 24'h000000;
    core_power_ok = 1'b1;
    sa0_strap     = 1'b0;
    nvm_trim      = 16'hA503;
    err_total     = 0;
    comparisons   = 0;
    tk(5);
    check({trim_loaded, sda_oe, sdo_oe}, 32'h0);
    tk(1);
    rst_b      = 1'b1;
    samp_rst_b = 1'b1;
    tk(6);
    check(trim_loaded, 32'h1);
    check({scl, sda}, 32'h3);
    rd({1'b1, ADSH_A_SENS}, 2, {16'h0000, nvm_trim.offs, nvm_trim.sens});
    wr({1'b0, ADSH_A_WAKE_TH}, 1, 32'h55);
    rd({1'b0, ADSH_A_WAKE_TH}, 1, 32'h55);
    d = 32'h0;
    u_adsh_bm.i2c({ADSH_ADDR_HI, 1'b1, 1'b0}, 8'h22, 1'b0, 1, d, nak);
    check(nak, 32'h1);
    sa0_strap = 1'b1;
    tk(6);
    wr({1'b1, ADSH_A_WAKE_EN}, 4, 32'h08071004);
    rd({1'b1, ADSH_A_WAKE_EN}, 4, 32'h08071004);
    rd({1'b0, ADSH_A_WAKE_TH}, 2, 32'h1010);
    $display("test two_wire finished");
    sp(1'b0, ADSH_A_FF_TH, 1, 1'b0, 16'h0900);
    sp(1'b1, ADSH_A_FF_TH, 1, 1'b0, 16'h0000);
    check(s[15:8], 32'h09);
    check(sdo_oe, 32'h0);
    sp(1'b0, ADSH_A_FF_EN, 2, 1'b0, 16'h0708);
    sp(1'b1, ADSH_A_FF_EN, 2, 1'b0, 16'h0000);
    check(s, 32'h0708);
    sp(1'b0, ADSH_A_CTRL, 1, 1'b0, 16'h0300);
    sp(1'b1, ADSH_A_WAKE_TH, 1, 1'b1, 16'h0000);
    check(s[15:8], 32'h10);
    sp(1'b0, ADSH_A_CTRL, 1, 1'b1, 16'h0200);
    sp(1'b1, ADSH_A_CTRL, 1, 1'b0, 16'h0000);
    check(s[15:8], {24'h000000, ADSH_CTRL_RST});
    s = 16'hEE00;
    u_adsh_bm.spi(1'b0, 1'b0, ADSH_A_WAKE_TH[5:0], 1, 1'b1, 1'b0, s);
    rd({1'b0, ADSH_A_WAKE_TH}, 1, 32'h10);
    $display("test serial_frame finished");
    samp({8'h40, 8'h00, 8'h00});
    wait_ready();
    check({int1_wake, int2_freefall}, 32'h2);
    rd({1'b0, ADSH_A_STATUS}, 1, 32'h1 << ADSH_ST_DRDY);
    rd({1'b1, ADSH_A_OUT_X}, 3, 32'h00FDFD3D);
    check(data_ready, 32'h0);
    samp({8'h02, 8'h03, 8'h04});
    wait_ready();
    check({int1_wake, int2_freefall}, 32'h1);
    rd({1'b0, ADSH_A_OUT_Z}, 1, 32'h01);
    check(data_ready, 32'h0);
    core_power_ok = 1'b0;
    tk(6);
    samp({8'h40, 8'h00, 8'h00});
    tk(20);
    check({data_ready, int1_wake, int2_freefall}, 32'h1);
    rd({1'b0, ADSH_A_WAKE_TH}, 1, 32'h10);
    $display("test samples_power finished");
    test_done();
  end
endmodule : adsh_host_port_tb
